// >>> hotplug_slot_control_tb_top.sv
// Purpose: Self-checking bench for the slot control block
// Assumes: Short command length to keep the run brief
// Notes: Slot pins come from the model, registers from tasks
module hotplug_slot_control_tb_top
    import hpsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic [4:0] pins;
    logic [1:0] att;
    logic [1:0] pwl;
    logic poff, lock, busy, hpirq, wake, irq;
    int n_mismatch = 0;
    int tests_run = 0;

    always #25 clk = !clk;

    hpsc_slot_ctrl #(.UPSTREAM(1'b0), .CMD_LEN(2)) i_dut (
        .core_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .button_i(pins[0]), .power_fault_i(pins[1]),
        .latch_open_i(pins[2]), .presence_i(pins[3]),
        .link_active_i(pins[4]), .attention_light_o(att),
        .power_light_o(pwl), .slot_power_off_o(poff),
        .interlock_engaged_o(lock), .cmd_busy_o(busy),
        .hotplug_irq_o(hpirq), .wake_o(wake), .irq_o(irq));

    hpsc_slot_model i_slot (.core_clk_i(clk),
        .slot_power_off_i(poff), .pins_o(pins));

    task chk(input string n, input logic [15:0] s, input logic [15:0] e);
        tests_run++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task wr_reg(input logic [11:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(negedge clk);
    endtask : wr_reg

    task rd_reg(input logic [11:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : rd_reg

    // Bounded wait so a stuck sequencer cannot hang the run
    task wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 50)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 50)
            n_mismatch++;
        repeat (3) @(negedge clk);
    endtask : wait_idle

    task wrap_up();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up

    task t_reset();
        @(negedge clk);
        chk("att", {14'h0, att}, 16'h0003);
        chk("pwl", {14'h0, pwl}, 16'h0001);
        chk("poff", {15'h0, poff}, 16'h0000);
    endtask : t_reset

    task t_caps();
        logic [15:0] q;
        wr_reg(SLOT_CTRL_OFS, 16'hffff);
        rd_reg(SLOT_CTRL_OFS, q);
        chk("ctl nocap", q, 16'h1000);
        wr_reg(SLOT_CAP_OFS, 16'h0040);
        wr_reg(SLOT_CTRL_OFS, 16'hffff);
        rd_reg(SLOT_CTRL_OFS, q);
        chk("ctl hpcap", q, 16'h1038);
        wr_reg(SLOT_CAP_OFS, 16'h007f);
        wr_reg(SLOT_CTRL_OFS, 16'hffff);
        rd_reg(SLOT_CTRL_OFS, q);
        chk("ctl full", q, 16'h17ff);
        chk("lock", {15'h0, lock}, 16'h0001);
        rd_reg(12'h200, q);
        chk("unmapped", q, 16'h0000);
        wait_idle();
    endtask : t_caps

    task t_lights();
        logic [1:0] v;
        logic [15:0] d;
        logic [15:0] q;
        for (int i = 0; i < 4; i++)
        begin
            v = i[1:0];
            d = {5'h0, v[0], v, v, 6'h00};
            wr_reg(SLOT_CTRL_OFS, d);
            chk("att", {14'h0, att}, {14'h0, v});
            chk("pwl", {14'h0, pwl}, {14'h0, v});
            chk("poff", {15'h0, poff}, {15'h0, v[0]});
            rd_reg(SLOT_CTRL_OFS, q);
            chk("ctl rb", q, d);
        end
        wait_idle();
    endtask : t_lights

    task t_lock();
        logic [2:0] pat;
        logic e;
        pat = 3'b101;
        e = 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            if (pat[i])
                e = !e;
            wr_reg(SLOT_CTRL_OFS, {4'h0, pat[i], 11'h000});
            chk("lock", {15'h0, lock}, {15'h0, e});
        end
        wait_idle();
    endtask : t_lock

    task t_cmd();
        logic [15:0] q;
        wr_reg(SLOT_STAT_OFS, 16'h011f);
        wr_reg(IRQ_STAT_OFS, 16'h0003);
        wr_reg(IRQ_MASK_OFS, 16'h0001);
        chk("irq idle", {15'h0, irq}, 16'h0000);
        wr_reg(SLOT_CTRL_OFS, 16'h0000);
        chk("busy", {15'h0, busy}, 16'h0001);
        wait_idle();
        rd_reg(SLOT_STAT_OFS, q);
        chk("cmd done", q & 16'h0010, 16'h0010);
        rd_reg(IRQ_STAT_OFS, q);
        chk("irq stat", q & 16'h0001, 16'h0001);
        chk("irq on", {15'h0, irq}, 16'h0001);
        wr_reg(IRQ_MASK_OFS, 16'h0000);
        chk("irq masked", {15'h0, irq}, 16'h0000);
        wr_reg(IRQ_MASK_OFS, 16'h0001);
        wr_reg(IRQ_STAT_OFS, 16'h0003);
        chk("irq clr", {15'h0, irq}, 16'h0000);
        wr_reg(SLOT_STAT_OFS, 16'h0010);
        rd_reg(SLOT_STAT_OFS, q);
        chk("cmd clr", q & 16'h0010, 16'h0000);
        wr_reg(SLOT_CTRL_OFS, 16'h0030);
        wait_idle();
        chk("cmd irq", {15'h0, hpirq}, 16'h0001);
        chk("cmd wake", {15'h0, wake}, 16'h0000);
    endtask : t_cmd

    task automatic t_events();
        int en [5] = '{0, 1, 2, 3, 12};
        int sb [5] = '{0, 1, 2, 3, 8};
        logic [15:0] q;
        for (int i = 0; i < 5; i++)
        begin
            wr_reg(SLOT_CTRL_OFS, 16'h0020 | (16'h0001 << en[i]));
            wait_idle();
            wr_reg(SLOT_STAT_OFS, 16'h011f);
            repeat (3) @(negedge clk);
            chk("hp idle", {15'h0, hpirq}, 16'h0000);
            i_slot.kick(i);
            repeat (6) @(negedge clk);
            chk("hp irq", {15'h0, hpirq}, 16'h0001);
            rd_reg(SLOT_STAT_OFS, q);
            chk("ev stat", q & 16'h011f, 16'h0001 << sb[i]);
            wr_reg(SLOT_CTRL_OFS, 16'h0001 << en[i]);
            wait_idle();
            chk("no master", {15'h0, hpirq}, 16'h0000);
            chk("wake", {15'h0, wake}, 16'h0001);
            wr_reg(SLOT_STAT_OFS, 16'h011f);
            repeat (3) @(negedge clk);
            chk("wake clr", {15'h0, wake}, 16'h0000);
        end
    endtask : t_events

    initial
    begin
        repeat (8) @(posedge clk);
        t_reset();
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_caps();
        t_lights();
        t_lock();
        t_cmd();
        t_events();
        wrap_up();
    end

    // The whole sequence needs about 270 cycles
    initial
    begin
        repeat (6000) @(posedge clk);
        n_mismatch++;
        wrap_up();
    end
endmodule : hotplug_slot_control_tb_top

// >>> hpsc_cmd_seq.sv
// Purpose: Command sequencer: one completion pulse after the last write
// Assumes: Actions finish in a fixed number of cycles
// Notes: Models the slow expander update of the slot outputs
module hpsc_cmd_seq
    import hpsc_pkg::*;
#(
    parameter int CYCLES = CMD_CYCLES
)
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    output logic busy_o,
    output logic done_o
);
    initial
    begin
        if (CYCLES < 1 || CYCLES > 255)
            $error("CYCLES out of range");
    end
    hpsc_cmd_t state_reg;
    logic [7:0] cnt_reg;
    // A write while busy restarts the count so completion follows the last
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_reg <= HPSC_IDLE;
            cnt_reg <= 8'h00;
        end
        else if (start_i)
        begin
            state_reg <= HPSC_BUSY;
            cnt_reg <= 8'(CYCLES - 1);
        end
        else
        begin
            case (state_reg)
                HPSC_BUSY:
                begin
                    if (cnt_reg == 8'h00)
                        state_reg <= HPSC_DONE;
                    else
                        cnt_reg <= cnt_reg - 8'h01;
                end
                HPSC_DONE: state_reg <= HPSC_IDLE;
                default: state_reg <= HPSC_IDLE;
            endcase
        end
    end
    assign busy_o = (state_reg == HPSC_BUSY);
    assign done_o = (state_reg == HPSC_DONE);
endmodule : hpsc_cmd_seq

// >>> hpsc_pkg.sv
// Purpose: Constants for the hot-plug slot control block
// Assumes: 16-bit registers on a plain strobe port
// Notes: Offsets are byte addresses
package hpsc_pkg;
    localparam logic [11:0] SLOT_CTRL_OFS = 12'h058;
    localparam logic [11:0] SLOT_STAT_OFS = 12'h05a;
    localparam logic [11:0] IRQ_STAT_OFS = 12'h100;
    localparam logic [11:0] IRQ_MASK_OFS = 12'h104;
    localparam logic [11:0] SLOT_CAP_OFS = 12'h108;
    localparam int BTN_EN_BIT = 0;
    localparam int PFAULT_EN_BIT = 1;
    localparam int LATCH_EN_BIT = 2;
    localparam int PRES_EN_BIT = 3;
    localparam int CMD_EN_BIT = 4;
    localparam int MASTER_EN_BIT = 5;
    localparam int ATT_LO = 6;
    localparam int PWRL_LO = 8;
    localparam int PWR_BIT = 10;
    localparam int LOCK_BIT = 11;
    localparam int LINK_EN_BIT = 12;
    localparam int CMD_STAT_BIT = 4;
    localparam int LINK_STAT_BIT = 8;
    localparam logic [1:0] ATT_RESET = 2'h3;
    localparam logic [1:0] PWRL_RESET = 2'h1;
    localparam logic PWR_RESET = 1'h0;
    localparam logic [15:0] CTRL_WMASK = 16'h1fff;
    localparam int CMD_CYCLES = 4;
    typedef enum logic [1:0]
    {
        HPSC_IDLE = 2'h0,
        HPSC_BUSY = 2'h1,
        HPSC_DONE = 2'h2
    } hpsc_cmd_t;
endpackage : hpsc_pkg

// >>> hpsc_slot_ctrl.sv
// Purpose: Slot control register bank for one switch port
// Assumes: Event inputs are asynchronous levels from the slot
// Notes: Capabilities are a software-written register here
//
// Design decision made here: the strobed register port.
module hpsc_slot_ctrl
    import hpsc_pkg::*;
#(
    parameter bit UPSTREAM = 1'b0,
    parameter int CMD_LEN = CMD_CYCLES
)
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [11:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    input wire logic button_i,
    input wire logic power_fault_i,
    input wire logic latch_open_i,
    input wire logic presence_i,
    input wire logic link_active_i,
    output logic [1:0] attention_light_o,
    output logic [1:0] power_light_o,
    output logic slot_power_off_o,
    output logic interlock_engaged_o,
    output logic cmd_busy_o,
    output logic hotplug_irq_o,
    output logic wake_o,
    output logic irq_o
);
    logic rst_s1_reg, rst_n_reg;
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_s1_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end
        else
        begin
            rst_s1_reg <= 1'b1;
            rst_n_reg <= rst_s1_reg;
        end
    end

    // Slot pins are asynchronous: two flops before any logic
    logic [4:0] pin_s1_reg, pin_s2_reg, pin_d_reg;
    always_ff @(posedge core_clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            pin_s1_reg <= 5'h00;
            pin_s2_reg <= 5'h00;
            pin_d_reg <= 5'h00;
        end
        else
        begin
            pin_s1_reg <= {link_active_i, presence_i, latch_open_i,
                power_fault_i, button_i};
            pin_s2_reg <= pin_s1_reg;
            pin_d_reg <= pin_s2_reg;
        end
    end
    // The delay flop clears to zero, so a pin already high at reset would
    // look like an edge; events stay quiet until the chain has filled
    logic [2:0] arm_reg;
    always_ff @(posedge core_clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            arm_reg <= 3'h0;
        else
            arm_reg <= {arm_reg[1:0], 1'b1};
    end
    logic armed;
    assign armed = arm_reg[2];
    logic btn_ev, pf_ev, latch_ev, pres_ev, link_ev;
    assign btn_ev = armed & pin_s2_reg[0] & ~pin_d_reg[0];
    assign pf_ev = armed & pin_s2_reg[1] & ~pin_d_reg[1];
    assign latch_ev = armed & (pin_s2_reg[2] ^ pin_d_reg[2]);
    assign pres_ev = armed & (pin_s2_reg[3] ^ pin_d_reg[3]);
    assign link_ev = armed & (pin_s2_reg[4] ^ pin_d_reg[4]);

    // Capabilities: 0 button, 1 power ctl, 2 latch, 3 att light,
    // 4 power light, 5 interlock, 6 hot-plug capable
    logic [6:0] cap_reg;
    logic wr_ctrl, wr_stat, wr_mask, wr_cap;
    assign wr_ctrl = wr_i && addr_i == SLOT_CTRL_OFS;
    assign wr_stat = wr_i && addr_i == SLOT_STAT_OFS;
    assign wr_mask = wr_i && addr_i == IRQ_MASK_OFS;
    assign wr_cap = wr_i && addr_i == SLOT_CAP_OFS;
    always_ff @(posedge core_clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            cap_reg <= 7'h00;
        else if (wr_cap)
            cap_reg <= wdata_i[6:0];
    end

    function automatic logic [15:0] cap_mask(input logic [6:0] c);
        logic [15:0] m;
        m = 16'h0000;
        m[BTN_EN_BIT] = c[0];
        m[PFAULT_EN_BIT] = c[1];
        m[LATCH_EN_BIT] = c[2];
        m[PRES_EN_BIT] = c[6];
        m[CMD_EN_BIT] = c[6];
        m[MASTER_EN_BIT] = c[6];
        m[ATT_LO +: 2] = {2{c[3]}};
        m[PWRL_LO +: 2] = {2{c[4]}};
        m[PWR_BIT] = c[1];
        m[LINK_EN_BIT] = 1'b1;
        return m;
    endfunction : cap_mask

    logic [15:0] ctrl_reg;
    logic lock_reg;
    logic [15:0] cm;
    assign cm = cap_mask(cap_reg);
    always_ff @(posedge core_clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            ctrl_reg <= 16'h0000;
            ctrl_reg[ATT_LO +: 2] <= ATT_RESET;
            ctrl_reg[PWRL_LO +: 2] <= PWRL_RESET;
            ctrl_reg[PWR_BIT] <= PWR_RESET;
        end
        else if (wr_ctrl)
        begin
            ctrl_reg[5:0] <= wdata_i[5:0];
            ctrl_reg[LINK_EN_BIT] <= wdata_i[LINK_EN_BIT];
            ctrl_reg[ATT_LO +: 2] <= wdata_i[ATT_LO +: 2];
            if (!UPSTREAM)
                ctrl_reg[PWRL_LO +: 2] <= wdata_i[PWRL_LO +: 2];
            ctrl_reg[PWR_BIT] <= wdata_i[PWR_BIT];
        end
    end
    always_ff @(posedge core_clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            lock_reg <= 1'b0;
        else if (wr_ctrl && wdata_i[LOCK_BIT] && cap_reg[5])
            lock_reg <= ~lock_reg;
    end

    logic [15:0] ctrl_view;
    assign ctrl_view = ctrl_reg & cm & CTRL_WMASK & ~(16'h0001 << LOCK_BIT);

    logic cmd_done;
    hpsc_cmd_seq #(.CYCLES(CMD_LEN)) u_cmd
    (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_reg),
        .start_i(wr_ctrl),
        .busy_o(cmd_busy_o),
        .done_o(cmd_done)
    );

    // Slot status: set beats write-one-clear
    logic [8:0] stat_reg, stat_set;
    assign stat_set = {link_ev, 3'h0, cmd_done, pres_ev, latch_ev, pf_ev,
        btn_ev};
    always_ff @(posedge core_clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            stat_reg <= 9'h000;
        else
            stat_reg <= (stat_reg & ~(wr_stat ? wdata_i[8:0] : 9'h000))
                | stat_set;
    end
    logic [8:0] stat_view;
    assign stat_view = {stat_reg[8], 1'b0, pin_s2_reg[3], pin_s2_reg[2],
        stat_reg[4:0]};

    logic [5:0] en_vec;
    assign en_vec = {ctrl_view[LINK_EN_BIT], ctrl_view[4:0]};
    logic [5:0] pend;
    assign pend = {stat_reg[LINK_STAT_BIT], stat_reg[4:0]} & en_vec;
    always_ff @(posedge core_clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            hotplug_irq_o <= 1'b0;
        else
            hotplug_irq_o <= ctrl_view[MASTER_EN_BIT] && |pend;
    end
    // Command completion never wakes the system
    always_ff @(posedge core_clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            wake_o <= 1'b0;
        else
            wake_o <= |(pend & 6'h2f);
    end

    // Block interrupt: 0 command done, 1 hot-plug request rise
    logic [1:0] ist_reg, imask_reg;
    logic hp_d_reg;
    logic wr_ist;
    logic [1:0] ist_clr, ist_set;
    assign wr_ist = wr_i && addr_i == IRQ_STAT_OFS;
    assign ist_clr = wr_ist ? wdata_i[1:0] : 2'h0;
    assign ist_set = {hotplug_irq_o & ~hp_d_reg, cmd_done};
    // Set wins when an event and its clear meet in one cycle
    always_ff @(posedge core_clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            hp_d_reg <= 1'b0;
        else
            hp_d_reg <= hotplug_irq_o;
    end
    always_ff @(posedge core_clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            ist_reg <= 2'h0;
        else
            ist_reg <= (ist_reg & ~ist_clr) | ist_set;
    end
    always_ff @(posedge core_clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            imask_reg <= 2'h0;
        else if (wr_mask)
            imask_reg <= wdata_i[1:0];
    end
    assign irq_o = |(ist_reg & imask_reg);

    always_ff @(posedge core_clk_i or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
            rdata_o <= 16'h0000;
        else if (rd_i)
        begin
            case (addr_i)
                SLOT_CTRL_OFS: rdata_o <= ctrl_view;
                SLOT_STAT_OFS: rdata_o <= {7'h00, stat_view};
                IRQ_STAT_OFS: rdata_o <= {14'h0000, ist_reg};
                IRQ_MASK_OFS: rdata_o <= {14'h0000, imask_reg};
                SLOT_CAP_OFS: rdata_o <= {9'h000, cap_reg};
                default: rdata_o <= 16'h0000;
            endcase
        end
        else
            rdata_o <= 16'h0000;
    end

    assign attention_light_o = ctrl_reg[ATT_LO +: 2];
    assign power_light_o = ctrl_reg[PWRL_LO +: 2];
    assign slot_power_off_o = ctrl_reg[PWR_BIT];
    assign interlock_engaged_o = lock_reg;

    initial
    begin
        if (CMD_LEN < 1 || CMD_LEN > 255)
            $error("CMD_LEN out of range");
    end

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_reg);

    master_gate_a: assert property (
        !ctrl_view[MASTER_EN_BIT] |=> !hotplug_irq_o)
        else $error("irq without master enable");
    irq_cause_a: assert property (
        ctrl_view[MASTER_EN_BIT] && |pend |=> hotplug_irq_o)
        else $error("irq missed");
    lock_read_a: assert property (!ctrl_view[LOCK_BIT])
        else $error("interlock bit reads one");
    resv_read_a: assert property (ctrl_view[15:13] == 3'h0)
        else $error("reserved bits set");
    att_cap_a: assert property (!cap_reg[3] |-> ctrl_view[7:6] == 2'h0)
        else $error("attention light visible");
    pwrl_cap_a: assert property (!cap_reg[4] |-> ctrl_view[9:8] == 2'h0)
        else $error("power light visible");
    btn_sticky_a: assert property (btn_ev |=> stat_reg[0])
        else $error("button flag lost");
    btn_clear_a: assert property (
        wr_stat && wdata_i[0] && !btn_ev |=> !stat_reg[0])
        else $error("button flag not cleared");
    wake_cmd_a: assert property (pend == 6'h10 |=> !wake_o)
        else $error("wake on command done");
    link_wake_a: assert property (
        stat_reg[LINK_STAT_BIT] && ctrl_view[LINK_EN_BIT] |=> wake_o)
        else $error("link change did not wake");
    latch_irq_a: assert property (
        stat_reg[2] && ctrl_view[LATCH_EN_BIT] && ctrl_view[MASTER_EN_BIT]
        |=> hotplug_irq_o)
        else $error("latch change irq missed");
    pres_irq_a: assert property (
        stat_reg[3] && ctrl_view[PRES_EN_BIT] && ctrl_view[MASTER_EN_BIT]
        |=> hotplug_irq_o)
        else $error("presence change irq missed");

    // Completion is tied to the sequencer, not a fixed cycle count,
    // because a write while busy restarts it
    cmd_start_a: assert property (wr_ctrl |=> cmd_busy_o)
        else $error("command not started");
    cmd_end_a: assert property ($fell(cmd_busy_o) |-> cmd_done)
        else $error("busy ended without completion");
    cmd_done_a: assert property (
        cmd_done |=> stat_reg[CMD_STAT_BIT] && ist_reg[0])
        else $error("command not completed");

    att_write_a: assert property (
        wr_ctrl |=> attention_light_o == $past(wdata_i[ATT_LO +: 2]))
        else $error("attention light not written");
    pwrl_write_a: assert property (
        wr_ctrl |=> power_light_o == (UPSTREAM ? $past(power_light_o)
            : $past(wdata_i[PWRL_LO +: 2])))
        else $error("power light write wrong");
    pwr_write_a: assert property (
        wr_ctrl |=> slot_power_off_o == $past(wdata_i[PWR_BIT]))
        else $error("slot power not written");
    lock_tog_a: assert property (
        wr_ctrl && wdata_i[LOCK_BIT] && cap_reg[5]
        |=> lock_reg != $past(lock_reg))
        else $error("interlock not toggled");
    lock_hold_a: assert property (
        !(wr_ctrl && wdata_i[LOCK_BIT] && cap_reg[5]) |=> $stable(lock_reg))
        else $error("interlock changed without a write");

    cmd_c: cover property (wr_ctrl ##[1:8] cmd_done);
    irq_c: cover property (btn_ev ##[1:4] hotplug_irq_o);
    w1c_c: cover property (wr_stat && stat_reg[0] ##1 !stat_reg[0]);
    wake_c: cover property (link_ev ##[1:4] wake_o);
endmodule : hpsc_slot_ctrl

// >>> hpsc_slot_model.sv
// Purpose: Slot hardware model: button, fault, latch, card, link
// Assumes: Pins change just after a rising edge of the core clock
// Notes: Pulsed pins fall back so each kick makes one rising edge
module hpsc_slot_model
(
    input wire logic core_clk_i,
    input wire logic slot_power_off_i,
    output logic [4:0] pins_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // Card present, latch closed, link down at power-up
    initial pins_o = 5'h08;

    task kick(input int k);
        @(posedge core_clk_i);
        pins_o[k] <= !pins_o[k];
        // Button and power fault are momentary, the rest are levels
        if (k < 2)
        begin
            repeat (2) @(posedge core_clk_i);
            pins_o[k] <= 1'b0;
        end
    endtask : kick
endmodule : hpsc_slot_model
